// File: common/smc_pkg.sv
// package: register layout, reset values and timing for the supply monitor
package smc_pkg;
	localparam logic [7:0]  SMC_CTRL_ADDR     = 8'hDF;
	localparam logic [7:0]  SMC_CTRL_RESET    = 8'hDE;
	localparam int          SMC_BIT_DGOOD     = 7;
	localparam int          SMC_BIT_AGOOD     = 6;
	localparam int          SMC_BIT_FLAG      = 5;
	localparam int          SMC_BIT_DTRIP_HI  = 4;
	localparam int          SMC_BIT_DTRIP_LO  = 3;
	localparam int          SMC_BIT_ATRIP_HI  = 2;
	localparam int          SMC_BIT_ATRIP_LO  = 1;
	localparam int          SMC_BIT_EN        = 0;
	// trip codes, shared by both supply fields
	localparam logic [1:0]  SMC_TRIP_4V63     = 2'h0;
	localparam logic [1:0]  SMC_TRIP_3V08     = 2'h1;
	localparam logic [1:0]  SMC_TRIP_2V93     = 2'h2;
	localparam logic [1:0]  SMC_TRIP_2V63     = 2'h3;
	// timing
	localparam longint      SMC_CLK_HZ        = 125_000_000;
	localparam longint      SMC_RECOVER_MS    = 250;
	localparam int          SMC_RECOVER_CYC   = int'(SMC_CLK_HZ * SMC_RECOVER_MS / 1000);
	localparam int          SMC_GLITCH_NS     = 1000;
	localparam int          SMC_GLITCH_CYC    = int'((SMC_GLITCH_NS * 125 + 999) / 1000);
	typedef enum logic [1:0] {
		SMC_ST_IDLE    = 2'b00,
		SMC_ST_LOW     = 2'b01,
		SMC_ST_RECOVER = 2'b10
	} smc_state_t;
endpackage

// File: common/smc_cmp_if.sv
// interface: filtered comparator levels between the conditioner and the controller
interface smc_cmp_if;
	logic d_good;
	logic a_good;
	modport src (output d_good, output a_good);
	modport dst (input d_good, input a_good);
endinterface

// File: rtl/smc_sync_filter.sv
// one comparator: two-flop synchroniser followed by a glitch filter
module smc_sync_filter #(
	parameter int FILT_CYC = smc_pkg::SMC_GLITCH_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// comparator
	input  wire logic cmp_async,
	output logic      level_q
);
	import smc_pkg::*;
	localparam int CW = $clog2(FILT_CYC + 1);
	logic          s1_reg;
	logic          s2_reg;
	logic [CW-1:0] cnt_reg;
	// synchroniser, reset to supply good
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
		end else begin
			s1_reg <= cmp_async;
			s2_reg <= s1_reg;
		end
	end
	// level accepted only after it holds FILT_CYC cycles
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			level_q <= 1'b1;
		end else if (s2_reg == level_q) begin
			cnt_reg <= '0;
		end else if (cnt_reg == CW'(FILT_CYC - 1)) begin
			cnt_reg <= '0;
			level_q <= s2_reg;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

// File: rtl/smc_cond.sv
// conditions both comparator outputs into the core clock domain
module smc_cond #(
	parameter int FILT_CYC = smc_pkg::SMC_GLITCH_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// raw comparators
	input  wire logic cmp_d_async,
	input  wire logic cmp_a_async,
	// filtered levels
	smc_cmp_if.src    cmp
);
	genvar i;
	logic [1:0] raw;
	logic [1:0] lvl;
	assign raw = {cmp_d_async, cmp_a_async};
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			smc_sync_filter #(.FILT_CYC(FILT_CYC)) u_sf (
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.cmp_async (raw[i]),
				.level_q   (lvl[i])
			);
		end
	endgenerate
	assign cmp.d_good = lvl[1];
	assign cmp.a_good = lvl[0];
endmodule

// File: rtl/smc_top.sv
// supply monitor control register, flag and recovery timer
// Operation
// - flag low-supply when either supply below threshold
// - set flag bit 5 when comparator low
// - clear flag after 250 ms recovery
// - software clear ignored while comparator low
// - bit 7 shows digital comparator, read-only
// - bit 6 shows analog comparator, read-only
// - irq gated by external enable bit
// - bits 4:3 select digital threshold
// - glitches filtered before setting flag
// - high variant: digital thresholds unusable, POR
// - low variant: POR equals lowest threshold
// - shared four-level encoding, analog bits 2:1
// - bit 0 enables monitor
module smc_top #(
	parameter int RECOVER_CYC = smc_pkg::SMC_RECOVER_CYC,
	parameter int FILT_CYC    = smc_pkg::SMC_GLITCH_CYC
) (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// special function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	// analog comparators, active high when supply good
	input  wire logic       cmp_d_async,
	input  wire logic       cmp_a_async,
	// interrupt enable from the secondary enable register
	input  wire logic       secondary_irq_enable_reg,
	// to analog and core
	output logic      [1:0] digital_trip_select,
	output logic      [1:0] analog_trip_select,
	output logic            monitor_enable,
	output logic            supply_irq
);
	import smc_pkg::*;
	localparam int TW = $clog2(RECOVER_CYC + 1);

	smc_cmp_if  cmp ();
	logic       flag_reg;
	logic       flag_next;
	logic [1:0] dtrip_reg;
	logic [1:0] atrip_reg;
	logic       en_reg;
	logic       dgood_reg;
	logic       agood_reg;
	logic [TW-1:0] tmr_reg;
	smc_state_t st_reg;
	smc_state_t st_next;
	logic       low_any;
	logic       wr_hit;
	logic       timeout;

	function automatic logic [7:0] smc_pack(input logic dg, input logic ag, input logic fl,
		input logic [1:0] dt, input logic [1:0] at, input logic en);
		smc_pack = {dg, ag, fl, dt, at, en};
	endfunction

	smc_cond #(.FILT_CYC(FILT_CYC)) u_cond (
		.clk_sys     (clk_sys),
		.rst_n       (rst_n),
		.cmp_d_async (cmp_d_async),
		.cmp_a_async (cmp_a_async),
		.cmp         (cmp)
	);

	assign wr_hit  = sfr_wr && (sfr_addr == SMC_CTRL_ADDR);
	assign low_any = en_reg && (!cmp.d_good || !cmp.a_good);
	assign timeout = (tmr_reg == TW'(RECOVER_CYC - 1));

	// live comparator status bits
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dgood_reg <= SMC_CTRL_RESET[SMC_BIT_DGOOD];
			agood_reg <= SMC_CTRL_RESET[SMC_BIT_AGOOD];
		end else begin
			dgood_reg <= cmp.d_good;
			agood_reg <= cmp.a_good;
		end
	end

	// writable control fields; threshold choice acts on the analog comparators
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dtrip_reg <= SMC_CTRL_RESET[SMC_BIT_DTRIP_HI:SMC_BIT_DTRIP_LO];
			atrip_reg <= SMC_CTRL_RESET[SMC_BIT_ATRIP_HI:SMC_BIT_ATRIP_LO];
			en_reg    <= SMC_CTRL_RESET[SMC_BIT_EN];
		end else if (wr_hit) begin
			dtrip_reg <= sfr_wdata[SMC_BIT_DTRIP_HI:SMC_BIT_DTRIP_LO];
			atrip_reg <= sfr_wdata[SMC_BIT_ATRIP_HI:SMC_BIT_ATRIP_LO];
			en_reg    <= sfr_wdata[SMC_BIT_EN];
		end
	end

	// recovery sequencer
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			SMC_ST_IDLE: begin
				if (low_any) begin
					st_next = SMC_ST_LOW;
				end
			end
			SMC_ST_LOW: begin
				if (!low_any) begin
					st_next = SMC_ST_RECOVER;
				end
			end
			SMC_ST_RECOVER: begin
				if (low_any) begin
					st_next = SMC_ST_LOW;
				end else if (timeout) begin
					st_next = SMC_ST_IDLE;
				end
			end
			default: begin
				st_next = SMC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_reg <= SMC_ST_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	// recovery timer restarts whenever a supply drops again
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tmr_reg <= '0;
		end else if (st_reg == SMC_ST_RECOVER && !low_any && !timeout) begin
			tmr_reg <= tmr_reg + 1'b1;
		end else begin
			tmr_reg <= '0;
		end
	end

	// flag: hardware set beats software clear
	always_comb begin
		flag_next = flag_reg;
		if (wr_hit) begin
			flag_next = sfr_wdata[SMC_BIT_FLAG];
		end
		if (st_reg == SMC_ST_RECOVER && timeout && !low_any) begin
			flag_next = 1'b0;
		end
		if (low_any) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flag_reg <= SMC_CTRL_RESET[SMC_BIT_FLAG];
		end else begin
			flag_reg <= flag_next;
		end
	end

	// registered outputs
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sfr_rdata           <= '0;
			supply_irq          <= 1'b0;
			digital_trip_select <= SMC_CTRL_RESET[SMC_BIT_DTRIP_HI:SMC_BIT_DTRIP_LO];
			analog_trip_select  <= SMC_CTRL_RESET[SMC_BIT_ATRIP_HI:SMC_BIT_ATRIP_LO];
			monitor_enable      <= SMC_CTRL_RESET[SMC_BIT_EN];
		end else begin
			if (sfr_rd && sfr_addr == SMC_CTRL_ADDR) begin
				sfr_rdata <= smc_pack(dgood_reg, agood_reg, flag_reg, dtrip_reg, atrip_reg, en_reg);
			end else begin
				sfr_rdata <= '0;
			end
			supply_irq          <= flag_reg && secondary_irq_enable_reg;
			digital_trip_select <= dtrip_reg;
			analog_trip_select  <= atrip_reg;
			monitor_enable      <= en_reg;
		end
	end
endmodule

// File: tb/smc_assertions.sv
// checker: port properties of the supply monitor
module smc_assertions #(
	parameter int RECOVER_CYC = 50,
	parameter int FILT_CYC    = 4
) (
	// block inputs
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rd,
	input wire logic       cmp_d_async,
	input wire logic       cmp_a_async,
	input wire logic       secondary_irq_enable_reg,
	// block outputs
	input wire logic [7:0] sfr_rdata,
	input wire logic [1:0] digital_trip_select,
	input wire logic [1:0] analog_trip_select,
	input wire logic       monitor_enable,
	input wire logic       supply_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LAT = FILT_CYC + 4;
	localparam int LIM = RECOVER_CYC + FILT_CYC + 8;
	int gc;
	wire logic wr_ctl = sfr_wr && sfr_addr == 8'hDF;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// cycles with both supplies good while monitoring
	always_ff @(posedge clk_sys) begin
		gc <= (rst_n && cmp_d_async && cmp_a_async && monitor_enable) ? gc + 1 : 0;
	end
	property p_gate; supply_irq |-> $past(secondary_irq_enable_reg); endproperty
	a_gate: assert property (p_gate) else $error("irq without enable");
	property p_dtrip; $past(wr_ctl, 2) |-> digital_trip_select == $past(sfr_wdata[4:3], 2); endproperty
	a_dtrip: assert property (p_dtrip) else $error("digital trip wrong");
	property p_atrip; $past(wr_ctl, 2) |-> analog_trip_select == $past(sfr_wdata[2:1], 2); endproperty
	a_atrip: assert property (p_atrip) else $error("analog trip wrong");
	property p_en; $past(wr_ctl, 2) |-> monitor_enable == $past(sfr_wdata[0], 2); endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_set_d; (!cmp_d_async && monitor_enable && secondary_irq_enable_reg) [*8] |-> ##[0:LAT] supply_irq;
	endproperty
	a_set_d: assert property (p_set_d) else $error("no irq on digital low");
	property p_set_a; (!cmp_a_async && monitor_enable && secondary_irq_enable_reg) [*8] |-> ##[0:LAT] supply_irq;
	endproperty
	a_set_a: assert property (p_set_a) else $error("no irq on analog low");
	property p_fall; $fell(supply_irq) && $past(secondary_irq_enable_reg) |-> $past(cmp_d_async && cmp_a_async, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("flag cleared while low");
	property p_rec; gc > LIM |-> !supply_irq; endproperty
	a_rec: assert property (p_rec) else $error("flag not recovered");
	c_irq: cover property (supply_irq);
	c_clear: cover property ($fell(supply_irq));
	c_read: cover property (sfr_rd ##1 sfr_rdata != 8'h00);
endmodule

bind smc_top smc_assertions #(.RECOVER_CYC(RECOVER_CYC), .FILT_CYC(FILT_CYC)) i_smc_assertions (.*);

// File: tb/test_supply_monitor_control.sv
// testbench: supply monitor control block
module test_supply_monitor_control;
	timeunit 1ns;
	timeprecision 1ps;
	import smc_pkg::*;
	localparam int RCY = 50;
	logic       clk_sys, rst_n, sfr_wr, sfr_rd, cmp_d_async, cmp_a_async, ien, monitor_enable, supply_irq;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, a;
	logic [1:0] digital_trip_select, analog_trip_select;
	logic [4:0] sh;
	int         failures, n_compared, seed, i;
	smc_top #(.RECOVER_CYC(RCY), .FILT_CYC(4)) i_smc_top (.secondary_irq_enable_reg(ien), .*);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic irq(input logic e);
		#1 chk({7'h00, supply_irq}, {7'h00, e});
	endtask
	function automatic logic [7:0] ctl(input logic dg, input logic ag, input logic fl);
		return {dg, ag, fl, sh};
	endfunction
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		tick(1);
		sfr_addr <= ad;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		tick(1);
		sfr_wr <= 1'b0;
		if (ad == SMC_CTRL_ADDR)
			sh = d[4:0];
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		tick(1);
		sfr_addr <= ad;
		sfr_rd <= 1'b1;
		tick(1);
		sfr_rd <= 1'b0;
		#1 chk(sfr_rdata, exp);
	endtask
	// one supply low, refused clear, gating, then timed recovery
	task automatic low(input logic d);
		int k;
		tick(1);
		cmp_d_async <= !d;
		cmp_a_async <= d;
		tick(15);
		irq(1'b1);
		wr(SMC_CTRL_ADDR, {3'b000, sh});
		rd(SMC_CTRL_ADDR, ctl(!d, d, 1'b1));
		tick(1);
		ien <= 1'b0;
		tick(2);
		irq(1'b0);
		tick(1);
		ien <= 1'b1;
		cmp_d_async <= 1'b1;
		cmp_a_async <= 1'b1;
		tick(RCY / 2);
		irq(1'b1);
		for (k = 0; k < 4 * RCY && supply_irq !== 1'b0; k++)
			#8;
		irq(1'b0);
		if (supply_irq !== 1'b0)
			end_of_test();
		rd(SMC_CTRL_ADDR, ctl(1'b1, 1'b1, 1'b0));
	endtask
	task automatic end_of_test;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		seed = 49863;
		failures = 0;
		n_compared = 0;
		sh = SMC_CTRL_RESET[4:0];
		{rst_n, sfr_wr, sfr_rd, ien} = 4'h0;
		{sfr_addr, sfr_wdata} = 16'h0000;
		{cmp_d_async, cmp_a_async} = 2'b11;
		tick(6);
		rst_n <= 1'b1;
		rd(SMC_CTRL_ADDR, SMC_CTRL_RESET);
		rd(8'hDE, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(SMC_CTRL_ADDR, {3'b000, i[1:0], ~i[1:0], 1'b1});
			rd(SMC_CTRL_ADDR, ctl(1'b1, 1'b1, 1'b0));
			chk({3'b000, digital_trip_select, analog_trip_select, monitor_enable}, {3'b000, sh});
		end
		tick(1);
		ien <= 1'b1;
		low(1'b1);
		low(1'b0);
		// short dip must not raise the flag
		tick(1);
		cmp_d_async <= 1'b0;
		tick(2);
		cmp_d_async <= 1'b1;
		tick(15);
		irq(1'b0);
		wr(SMC_CTRL_ADDR, {3'b000, sh[4:1], 1'b0});
		tick(1);
		cmp_a_async <= 1'b0;
		tick(15);
		rd(SMC_CTRL_ADDR, ctl(1'b1, 1'b0, 1'b0));
		tick(1);
		cmp_a_async <= 1'b1;
		tick(12);
		for (i = 0; i < 40; i++) begin
			a = i[0] ? 8'($random(seed)) : SMC_CTRL_ADDR;
			tick(1);
			ien <= 1'($random(seed));
			wr(a, 8'($random(seed)) & 8'hDF);
			rd(SMC_CTRL_ADDR, ctl(1'b1, 1'b1, 1'b0));
		end
		end_of_test();
	end
endmodule
